// >>> rtl/rtcsf_pkg.sv
// Shared constants and types of the RTC status-flag and trim block
package rtcsf_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned OSC_HZ = 32768;
  // Timebase runs at twice the oscillator so the square wave is 50 %
  localparam int unsigned OSC_X2_HZ = 2 * OSC_HZ;
  localparam int unsigned ACC_W = 29;
  localparam logic [15:0] SEC_LAST = 16'h7FFF;
  // One 3.05 ppm step over a 20 s window of 32768 Hz ticks
  localparam logic [7:0] TRIM_STEP_TICKS = 8'h02;
  localparam logic [5:0] TRIM_SEC_0 = 6'h00;
  localparam logic [5:0] TRIM_SEC_1 = 6'h14;
  localparam logic [5:0] TRIM_SEC_2 = 6'h28;
  localparam logic [5:0] SEC_MAX = 6'h3B;

  ////////////////////////////////////////////////////////////////////////
  // Register map: index as printed, byte address is four times it
  localparam logic [3:0] IDX_TRIM = 4'h7;
  localparam logic [3:0] IDX_CTRL1 = 4'hE;
  localparam logic [3:0] IDX_CTRL2 = 4'hF;
  localparam logic [5:0] ADDR_TRIM = {IDX_TRIM, 2'b00};
  localparam logic [5:0] ADDR_CTRL1 = {IDX_CTRL1, 2'b00};
  localparam logic [5:0] ADDR_CTRL2 = {IDX_CTRL2, 2'b00};

  // Control 2 bit positions
  localparam int unsigned C2_VDSL = 7;
  localparam int unsigned C2_XST = 5;
  localparam int unsigned C2_PON = 4;
  localparam int unsigned C2_CLEN = 3;
  localparam int unsigned C2_PERIODIC_IRQ_FLAG = 2;
  localparam int unsigned C2_WEEKDAY_ALARM_FLAG = 1;
  localparam int unsigned C2_DAILY_ALARM_FLAG = 0;

  // Reset values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [6:0] TRIM_RST = 7'h00;

  ////////////////////////////////////////////////////////////////////////
  // Trim code boundaries
  localparam logic [6:0] TRIM_SLOW_MIN = 7'h02;
  localparam logic [6:0] TRIM_SLOW_MAX = 7'h3F;
  localparam logic [6:0] TRIM_FAST_MIN = 7'h42;

  // Periodic select codes
  localparam logic [2:0] CT_OFF = 3'h0;
  localparam logic [2:0] CT_LOW = 3'h1;
  localparam logic [2:0] CT_2HZ = 3'h2;
  localparam logic [2:0] CT_1HZ = 3'h3;
  localparam logic [2:0] CT_SEC = 3'h4;
  localparam logic [2:0] CT_MIN = 3'h5;
  localparam logic [2:0] CT_HOUR = 3'h6;
  localparam logic [2:0] CT_MONTH = 3'h7;

  typedef struct packed {
    logic weekday_alarm_enable;
    logic daily_alarm_enable;
    logic hour_24;
    logic clkout_disable_b;
    logic test_mode;
    logic [2:0] periodic_select;
  } rtcsf_ctrl1_t;

endpackage : rtcsf_pkg

// >>> rtl/rtcsf_top.sv
// Status flags, periodic interrupt, clock output and trim of the RTC
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Operation
// - Power-on event sets flag, held until cleared
// - Writing zero clears power-on flag, re-arms
// - Power-on flag forces trim and controls zero
// - Power-on flag releases both interrupt pins
// - Both disable bits stop clock output
// - Periodic flag reads periodic pin drive state
// - Periodic clear only in level mode
// - Periodic flag sets again next event
// - Weekday flag set on match when enabled
// - Weekday flag clear releases second pin
// - Daily flag set on match when enabled
// - Daily clear releases first pin if periodic off
// - Trim top bit reads zero
// - Trim steps 3.05 ppm up to 189.1
// - Trim code maps to slow or fast steps
// - Trim applied at seconds 00, 20, 40
// - Trim leaves clock output square wave alone
// - Trim changes that periodic cycle length
// - Daily match drives first pin low
// - Weekday match drives second pin low
// - Periodic select chooses first pin behaviour
module rtcsf_top #(
  parameter int unsigned CLK_HZ = rtcsf_pkg::CLK_HZ
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic clkout_enable_pin,
  input wire logic power_drop_reset,
  input wire logic osc_stop_detect,
  input wire logic daily_alarm_match,
  input wire logic weekday_alarm_match,
  input wire logic hour_event,
  input wire logic month_event,
  output logic second_tick,
  output logic clkout_pin,
  output logic irq_a_pin_o,
  output logic irq_a_pin_oe,
  output logic irq_b_pin_o,
  output logic irq_b_pin_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: bit 0 enable, bit 1 power drop, bit 2 osc stop
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic fen_s;
  logic por_s;
  logic ostop_s;

  always_ff @(posedge core_clk) begin
    pin_meta_q <= {osc_stop_detect, power_drop_reset, clkout_enable_pin};
    pin_sync_q <= pin_meta_q;
  end

  assign fen_s = pin_sync_q[0];
  assign por_s = pin_sync_q[1];
  assign ostop_s = pin_sync_q[2];

  ////////////////////////////////////////////////////////////////////////
  // Oscillator timebase from a phase accumulator
  // Fractional ratio keeps the long-term rate exact at any core clock
  // Core clock must run at least twice the oscillator rate
  logic [rtcsf_pkg::ACC_W-1:0] acc_q;
  logic [rtcsf_pkg::ACC_W-1:0] acc_sum;
  logic [rtcsf_pkg::ACC_W-1:0] acc_d;
  logic x2_tick;
  logic phase_q;
  logic osc_tick;

  assign acc_sum = acc_q
    + rtcsf_pkg::ACC_W'(rtcsf_pkg::OSC_X2_HZ);
  assign x2_tick = acc_sum >= rtcsf_pkg::ACC_W'(CLK_HZ);
  assign acc_d = x2_tick ? acc_sum - rtcsf_pkg::ACC_W'(CLK_HZ)
                         : acc_sum;
  assign osc_tick = x2_tick & phase_q;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      acc_q <= '0;
      phase_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      if (x2_tick) begin
        phase_q <= ~phase_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register storage
  logic pon_q;
  logic xst_q;
  logic vdsl_q;
  logic clen_a_q;
  logic weekday_alarm_flag_q;
  logic daily_alarm_flag_q;
  logic lvl_q;
  logic [6:0] trim_q;
  rtcsf_pkg::rtcsf_ctrl1_t c1_q;
  // Second counters, read by the trim decode below
  logic [15:0] presc_q;
  logic [5:0] sec_q;

  ////////////////////////////////////////////////////////////////////////
  // Trim decode
  logic trim_second;
  logic trim_slow;
  logic trim_fast;
  logic [6:0] slow_steps;
  logic [6:0] fast_steps;
  logic [7:0] slow_ext;
  logic [7:0] fast_cut;
  logic [15:0] sec_last;

  assign trim_second = (sec_q == rtcsf_pkg::TRIM_SEC_0)
                     | (sec_q == rtcsf_pkg::TRIM_SEC_1)
                     | (sec_q == rtcsf_pkg::TRIM_SEC_2);
  assign trim_slow = (trim_q >= rtcsf_pkg::TRIM_SLOW_MIN)
                   & (trim_q <= rtcsf_pkg::TRIM_SLOW_MAX);
  assign trim_fast = trim_q >= rtcsf_pkg::TRIM_FAST_MIN;
  assign slow_steps = trim_q - 7'h01;
  assign fast_steps = 7'h00 - trim_q;
  // Each step is two oscillator ticks within the 20 s window
  assign slow_ext = 8'({1'b0, slow_steps} * rtcsf_pkg::TRIM_STEP_TICKS);
  assign fast_cut = 8'({1'b0, fast_steps} * rtcsf_pkg::TRIM_STEP_TICKS);
  // The four no-correction codes leave the second as is
  assign sec_last = !trim_second ? rtcsf_pkg::SEC_LAST
    : trim_slow ? rtcsf_pkg::SEC_LAST + {8'h00, slow_ext}
    : trim_fast ? rtcsf_pkg::SEC_LAST - {8'h00, fast_cut}
    : rtcsf_pkg::SEC_LAST;

  ////////////////////////////////////////////////////////////////////////
  // Second prescaler and seconds position
  // Only this counter is trimmed; the square wave stays untouched
  logic sec_end;
  logic min_end;

  assign sec_end = osc_tick & (presc_q == sec_last);
  assign min_end = sec_end & (sec_q == rtcsf_pkg::SEC_MAX);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      presc_q <= '0;
      sec_q <= '0;
    end else if (sec_end) begin
      presc_q <= '0;
      sec_q <= min_end ? 6'h00 : sec_q + 6'h01;
    end else if (osc_tick) begin
      presc_q <= presc_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Periodic interrupt source
  logic [2:0] ct;
  logic level_mode;
  logic lvl_evt;
  logic pulse_2hz_low;
  logic pulse_1hz_low;
  logic periodic_on;

  assign ct = c1_q.periodic_select;
  assign level_mode = ct[2];
  // Stretched ticks land in the low half, so the cycle length moves
  assign pulse_2hz_low = ~presc_q[13];
  assign pulse_1hz_low = presc_q[15:14] != 2'b01;
  assign lvl_evt = ((ct == rtcsf_pkg::CT_SEC) & sec_end)
                 | ((ct == rtcsf_pkg::CT_MIN) & min_end)
                 | ((ct == rtcsf_pkg::CT_HOUR) & hour_event)
                 | ((ct == rtcsf_pkg::CT_MONTH) & month_event);
  assign periodic_on = (ct == rtcsf_pkg::CT_LOW)
    | ((ct == rtcsf_pkg::CT_2HZ) & pulse_2hz_low)
    | ((ct == rtcsf_pkg::CT_1HZ) & pulse_1hz_low)
    | (level_mode & lvl_q);

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the access commits
  logic wait_q;
  logic wait_d;
  logic req;
  logic commit;
  logic lane0;
  logic [7:0] wdat;
  logic wr_go;
  logic hit_trim;
  logic hit_c1;
  logic hit_c2;
  logic wr_trim;
  logic wr_c1;
  logic wr_c2;

  assign req = avs_read | avs_write;
  assign wait_d = ~(req & wait_q);
  assign commit = req & ~wait_q;
  assign lane0 = avs_byteenable[0];
  assign wdat = avs_writedata[7:0];
  assign wr_go = avs_write & commit & lane0;
  assign hit_trim = avs_address == rtcsf_pkg::ADDR_TRIM;
  assign hit_c1 = avs_address == rtcsf_pkg::ADDR_CTRL1;
  assign hit_c2 = avs_address == rtcsf_pkg::ADDR_CTRL2;
  assign wr_trim = wr_go & hit_trim;
  assign wr_c1 = wr_go & hit_c1;
  assign wr_c2 = wr_go & hit_c2;

  ////////////////////////////////////////////////////////////////////////
  // Read view
  logic weekday_alarm_flag_rd;
  logic daily_alarm_flag_rd;
  logic [7:0] c2_rd;
  logic [7:0] rd_byte;
  logic [31:0] rd_word;

  assign weekday_alarm_flag_rd = weekday_alarm_flag_q & c1_q.weekday_alarm_enable;
  assign daily_alarm_flag_rd = daily_alarm_flag_q & c1_q.daily_alarm_enable;
  assign c2_rd = {vdsl_q, 1'b0, xst_q, pon_q, clen_a_q,
                  periodic_on & ~pon_q, weekday_alarm_flag_rd, daily_alarm_flag_rd};
  assign rd_byte = hit_trim ? {1'b0, trim_q}
                 : hit_c1 ? c1_q
                 : hit_c2 ? c2_rd
                 : 8'h00;
  assign rd_word = {24'h000000, rd_byte};

  ////////////////////////////////////////////////////////////////////////
  // Next values of the flags
  logic clr_pon;
  logic clr_periodic_irq_flag;
  logic clr_weekday_alarm_flag;
  logic clr_daily_alarm_flag;
  logic set_weekday_alarm_flag;
  logic set_daily_alarm_flag;
  logic pon_d;
  logic xst_d;
  logic weekday_alarm_flag_d;
  logic daily_alarm_flag_d;
  logic lvl_d;

  assign clr_pon = wr_c2 & ~wdat[rtcsf_pkg::C2_PON];
  assign clr_periodic_irq_flag = wr_c2 & ~wdat[rtcsf_pkg::C2_PERIODIC_IRQ_FLAG];
  assign clr_weekday_alarm_flag = wr_c2 & ~wdat[rtcsf_pkg::C2_WEEKDAY_ALARM_FLAG];
  assign clr_daily_alarm_flag = wr_c2 & ~wdat[rtcsf_pkg::C2_DAILY_ALARM_FLAG];
  assign set_weekday_alarm_flag = weekday_alarm_match
                  & c1_q.weekday_alarm_enable;
  assign set_daily_alarm_flag = daily_alarm_match
                  & c1_q.daily_alarm_enable;
  // Writes of one to event flags simply fall through unused
  assign pon_d = por_s | (pon_q & ~clr_pon);
  // An oscillator stop beats a host write so none is missed
  assign xst_d = ostop_s ? 1'b0
               : (wr_c2 & wdat[rtcsf_pkg::C2_XST]) | xst_q;
  assign weekday_alarm_flag_d = pon_q ? 1'b0
                : set_weekday_alarm_flag | (weekday_alarm_flag_q & ~clr_weekday_alarm_flag);
  assign daily_alarm_flag_d = pon_q ? 1'b0
                : set_daily_alarm_flag | (daily_alarm_flag_q & ~clr_daily_alarm_flag);
  assign lvl_d = (pon_q | ~level_mode) ? 1'b0
               : lvl_evt | (lvl_q & ~clr_periodic_irq_flag);

  ////////////////////////////////////////////////////////////////////////
  // Next values of the stored controls
  logic vdsl_d;
  logic clen_a_d;
  logic [6:0] trim_d;
  rtcsf_pkg::rtcsf_ctrl1_t c1_d;

  assign vdsl_d = pon_q ? 1'b0
                : wr_c2 ? wdat[rtcsf_pkg::C2_VDSL] : vdsl_q;
  assign clen_a_d = pon_q ? 1'b0
                  : wr_c2 ? wdat[rtcsf_pkg::C2_CLEN] : clen_a_q;
  assign trim_d = pon_q ? rtcsf_pkg::TRIM_RST
                : wr_trim ? wdat[6:0] : trim_q;
  assign c1_d = pon_q ? rtcsf_pkg::CTRL1_RST
              : wr_c1 ? wdat : c1_q;

  ////////////////////////////////////////////////////////////////////////
  // Flag and control registers
  // A synchronous reset counts as a power-on event
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pon_q <= 1'b1;
      xst_q <= 1'b0;
      weekday_alarm_flag_q <= 1'b0;
      daily_alarm_flag_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      pon_q <= pon_d;
      xst_q <= xst_d;
      weekday_alarm_flag_q <= weekday_alarm_flag_d;
      daily_alarm_flag_q <= daily_alarm_flag_d;
      lvl_q <= lvl_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      vdsl_q <= 1'b0;
      clen_a_q <= 1'b0;
      trim_q <= rtcsf_pkg::TRIM_RST;
      c1_q <= rtcsf_pkg::CTRL1_RST;
    end else begin
      vdsl_q <= vdsl_d;
      clen_a_q <= clen_a_d;
      trim_q <= trim_d;
      c1_q <= c1_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive
  logic irq_a_d;
  logic irq_b_d;
  logic clkout_d;
  logic clk_stop;

  // Pins follow the flags one cycle late
  assign irq_a_d = ~pon_q
                 & (periodic_on | daily_alarm_flag_rd);
  assign irq_b_d = ~pon_q & weekday_alarm_flag_rd;
  // With the enable pin low the disable bits are plain storage
  assign clk_stop = c1_q.clkout_disable_b & clen_a_q;
  assign clkout_d = fen_s & ~clk_stop & phase_q;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq_a_pin_oe <= 1'b0;
      irq_b_pin_oe <= 1'b0;
      clkout_pin <= 1'b0;
      second_tick <= 1'b0;
    end else begin
      irq_a_pin_oe <= irq_a_d;
      irq_b_pin_oe <= irq_b_d;
      clkout_pin <= clkout_d;
      second_tick <= sec_end;
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge core_clk) begin
    irq_a_pin_o <= 1'b0;
    irq_b_pin_o <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus answer registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      avs_waitrequest <= wait_d;
      if (req & wait_q) begin
        avs_readdata <= rd_word;
      end
    end
  end

  assign wait_q = avs_waitrequest;

endmodule : rtcsf_top

// >>> tb/rtcsf_host.sv
// Host model: Avalon-MM master that reaches the block registers
`timescale 1ns/1ps
module rtcsf_host (
  input wire logic core_clk,
  input wire logic avs_waitrequest,
  output logic [5:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  initial begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h1;
  end
  // One byte in lane 0; request held until waitrequest is seen low
  task automatic xfer(input logic wr, input logic [5:0] a,
                      input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : xfer
endmodule : rtcsf_host

// >>> tb/rtcsf_props.sv
// Port checks of the RTC status flag and trim block
`timescale 1ns/1ps
module rtcsf_props #(
  parameter int unsigned CLK_HZ = rtcsf_pkg::CLK_HZ
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic power_drop_reset,
  input wire logic weekday_alarm_match,
  input wire logic second_tick,
  input wire logic clkout_pin,
  input wire logic irq_a_pin_o,
  input wire logic irq_a_pin_oe,
  input wire logic irq_b_pin_o,
  input wire logic irq_b_pin_oe
);
  // Half period of the square wave in core cycles
  localparam int HALF = int'(CLK_HZ / rtcsf_pkg::OSC_X2_HZ);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("no answer");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("long answer");
  property p_rst;
    $rose(resetn) |-> !irq_a_pin_oe && !irq_b_pin_oe && !second_tick;
  endproperty
  a_rst: assert property (p_rst) else $error("pins after reset");
  property p_pwr;
    power_drop_reset [*6] |=> !irq_a_pin_oe && !irq_b_pin_oe;
  endproperty
  a_pwr: assert property (p_pwr) else $error("pins on power-on");
  property p_b_rise;
    $rose(irq_b_pin_oe) |-> $past(weekday_alarm_match, 2);
  endproperty
  a_b_rise: assert property (p_b_rise) else $error("pin b no cause");
  property p_b_fall;
    $fell(irq_b_pin_oe) |->
      $past(avs_write && !avs_waitrequest, 2) || $past(power_drop_reset, 4);
  endproperty
  a_b_fall: assert property (p_b_fall) else $error("pin b dropped");
  property p_trim_msb;
    avs_read && !avs_waitrequest && avs_address == rtcsf_pkg::ADDR_TRIM
      |-> avs_readdata[7] == 1'b0;
  endproperty
  a_trim_msb: assert property (p_trim_msb) else $error("trim bit7");
  property p_rd_hi;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("read upper bits");
  property p_od;
    irq_a_pin_o == 1'b0 && irq_b_pin_o == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  // A core clock not a whole multiple of twice the oscillator rate would trip this; bench avoids that
  property p_clk;
    $rose(clkout_pin) |-> ##HALF !clkout_pin;
  endproperty
  a_clk: assert property (p_clk) else $error("clkout half period");
endmodule : rtcsf_props
bind rtcsf_top rtcsf_props #(.CLK_HZ(CLK_HZ)) u_rtcsf_props (
  .core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .power_drop_reset(power_drop_reset),
  .weekday_alarm_match(weekday_alarm_match), .second_tick(second_tick),
  .clkout_pin(clkout_pin), .irq_a_pin_o(irq_a_pin_o),
  .irq_a_pin_oe(irq_a_pin_oe), .irq_b_pin_o(irq_b_pin_o),
  .irq_b_pin_oe(irq_b_pin_oe));

// >>> tb/tb.sv
// Self-checking bench of the RTC status flags, clock output and trim
`timescale 1ns/1ps
module tb;
  localparam logic [5:0] A_TR = rtcsf_pkg::ADDR_TRIM;
  localparam logic [5:0] A_C1 = rtcsf_pkg::ADDR_CTRL1;
  localparam logic [5:0] A_C2 = rtcsf_pkg::ADDR_CTRL2;
  // Slowest legal core clock keeps one trimmed second inside the run
  localparam int CLK_SIM = 65536;
  localparam int RST_CYC = 12;
  localparam int TPO = CLK_SIM / int'(rtcsf_pkg::OSC_HZ);
  int steps;
  int exp_tick;
  int tick_at = 0;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [7:0] exp_q[$];
  logic core_clk, resetn, clkout_enable_pin, power_drop_reset;
  logic osc_stop_detect, daily_alarm_match, weekday_alarm_match;
  logic hour_event, month_event, second_tick, clkout_pin, avs_waitrequest;
  logic avs_read, avs_write, irq_a_pin_o, irq_a_pin_oe;
  logic irq_b_pin_o, irq_b_pin_oe;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [7:0] code;
  // Open-drain wires with pull-ups
  wire irq_a_pin = irq_a_pin_oe ? irq_a_pin_o : 1'b1;
  wire irq_b_pin = irq_b_pin_oe ? irq_b_pin_o : 1'b1;

  rtcsf_top #(.CLK_HZ(CLK_SIM)) u_rtcsf_top (.*);
  rtcsf_host u_rtcsf_host (.core_clk(core_clk),
    .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (exp_q.size() != 0)
      errors++;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic cmp(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", what, e, g);
    end
  endtask : cmp
  task automatic cmp_tick(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected second_tick exp %0d got %0d", e, g);
    end
  endtask : cmp_tick
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_rtcsf_host.xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_rtcsf_host.xfer(1'b0, a, 8'h00);
  endtask : rd
  task automatic pins(input logic a, input logic b);
    repeat (3) @(posedge core_clk);
    cmp("irq_a_pin", {7'h00, a}, {7'h00, irq_a_pin});
    cmp("irq_b_pin", {7'h00, b}, {7'h00, irq_b_pin});
  endtask : pins
  task automatic ev(input logic [3:0] m);
    {month_event, hour_event, weekday_alarm_match, daily_alarm_match} <= m;
    @(posedge core_clk);
    {month_event, hour_event, weekday_alarm_match, daily_alarm_match} <= 4'h0;
  endtask : ev
  task automatic ck(input logic run);
    logic saw;
    saw = 1'b0;
    // Let a control write or the pin synchroniser settle first
    repeat (4) @(posedge core_clk);
    repeat (16) begin
      @(posedge core_clk);
      saw = saw | clkout_pin;
    end
    cmp("clkout_pin", {7'h00, run}, {7'h00, saw});
  endtask : ck
  // Read results are judged here, oldest note first
  always @(posedge core_clk) begin
    cycles++;
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      cmp("readdata", exp_q.pop_front(), avs_readdata[7:0]);
    if (second_tick === 1'b1 && tick_at == 0)
      tick_at = cycles;
    if (cycles == 70000) begin
      errors++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, power_drop_reset, osc_stop_detect, daily_alarm_match} = 0;
    {weekday_alarm_match, hour_event, month_event} = 0;
    clkout_enable_pin = 1'b1;
    void'($urandom(32'h531834E8));
    repeat (RST_CYC) @(posedge core_clk);
    resetn <= 1'b1;
    rd(A_C2, 8'h10);
    wr(A_C1, 8'hFF);
    rd(A_C1, 8'h00);
    pins(1'b1, 1'b1);
    wr(A_C2, 8'h00);
    rd(A_C2, 8'h00);
    wr(A_C2, 8'h08);
    rd(A_C2, 8'h08);
    wr(A_C1, 8'h10);
    ck(1'b0);
    wr(A_C2, 8'h00);
    ck(1'b1);
    clkout_enable_pin <= 1'b0;
    ck(1'b0);
    clkout_enable_pin <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      code = 8'($urandom_range(0, 127));
      wr(A_TR, code);
      rd(A_TR, code);
    end
    wr(A_TR, 8'h00);
    rd(A_TR, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(A_C1, 8'(i));
      rd(A_C1, 8'(i));
    end
    wr(A_C1, 8'h01);
    pins(1'b0, 1'b1);
    wr(A_C2, 8'h00);
    rd(A_C2, 8'h04);
    wr(A_C1, 8'h46);
    wr(A_C2, 8'h00);
    pins(1'b1, 1'b1);
    ev(4'h1);
    pins(1'b0, 1'b1);
    rd(A_C2, 8'h01);
    ev(4'h4);
    rd(A_C2, 8'h05);
    hour_event <= 1'b1;
    wr(A_C2, 8'h00);
    hour_event <= 1'b0;
    pins(1'b0, 1'b1);
    rd(A_C2, 8'h04);
    wr(A_C2, 8'h00);
    pins(1'b1, 1'b1);
    wr(A_C1, 8'h07);
    ev(4'h9);
    rd(A_C2, 8'h04);
    wr(A_C1, 8'h47);
    daily_alarm_match <= 1'b1;
    wr(A_C2, 8'h00);
    daily_alarm_match <= 1'b0;
    pins(1'b0, 1'b1);
    rd(A_C2, 8'h01);
    wr(A_C2, 8'h00);
    pins(1'b1, 1'b1);
    wr(A_C1, 8'h80);
    ev(4'h2);
    pins(1'b1, 1'b0);
    rd(A_C2, 8'h02);
    wr(A_C2, 8'h00);
    pins(1'b1, 1'b1);
    weekday_alarm_match <= 1'b1;
    wr(A_C2, 8'h00);
    weekday_alarm_match <= 1'b0;
    rd(A_C2, 8'h02);
    wr(A_C2, 8'h20);
    power_drop_reset <= 1'b1;
    repeat (6) @(posedge core_clk);
    power_drop_reset <= 1'b0;
    pins(1'b1, 1'b1);
    rd(A_C2, 8'h30);
    rd(A_C1, 8'h00);
    wr(A_C2, 8'h20);
    rd(A_C2, 8'h20);
    wr(6'h00, 8'hFF);
    rd(6'h00, 8'h00);
    code = 8'($urandom_range(0, 127));
    wr(A_TR, code);
    steps = (code >= 8'h02 && code <= 8'h3F) ? int'(code) - 1
          : (code >= 8'h42) ? int'(code) - 128 : 0;
    // First out-of-reset edge, one idle phase, registered pulse
    exp_tick = RST_CYC + 3 + TPO * (int'(rtcsf_pkg::SEC_LAST)
             + steps * int'(rtcsf_pkg::TRIM_STEP_TICKS));
    wait (tick_at != 0);
    cmp_tick(exp_tick, tick_at);
    repeat (2) @(posedge core_clk);
    final_report();
  end
endmodule : tb
